// [ccu_capture_compare.sv]
// Capture/compare unit with companion timer and register port
// ----------------------------------------
// ----------------------------------------
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/10ps

module ccu_capture_compare
    import ccu_pkg::*;
#(
    parameter bit SECOND_INSTANCE = 1'b0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rd_data,
    // Event pin
    input wire logic unit_event_pin_in,
    output logic unit_event_pin_out,
    output logic unit_event_pin_oe,
    // System outputs
    output logic irq,
    output logic converter_start
);

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (SECOND_INSTANCE !== 1'b0 && SECOND_INSTANCE !== 1'b1) begin : g_chk
        $error("SECOND_INSTANCE must be 0 or 1");
    end

    // ----------------------------------------
    // Mode decoding
    // ----------------------------------------
    function automatic logic is_capture(input logic [3:0] m);
        is_capture = (m >= CCU_M_CAP_FALL) && (m <= CCU_M_CAP_DIV16);
    endfunction

    function automatic logic is_compare(input logic [3:0] m);
        is_compare = (m >= CCU_M_CMP_HIGH) && (m <= CCU_M_CMP_SPECIAL);
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [2:0] sync;
    logic [2:0] next_sync;
    logic [3:0] unit_mode_field;
    logic [3:0] next_mode;
    logic [15:0] capture_compare_value;
    logic [15:0] next_value;
    logic [15:0] companion_timer_count;
    logic [15:0] next_timer;
    logic timer_run;
    logic next_timer_run;
    logic [1:0] status;
    logic [1:0] next_status;
    logic [1:0] mask;
    logic [1:0] next_mask;
    logic [3:0] presc;
    logic [3:0] next_presc;
    logic match_d;
    logic next_match_d;
    logic next_pin_out;
    logic next_pin_oe;
    logic next_irq;
    logic next_conv;
    logic [7:0] next_rd_data;
    logic rise;
    logic fall;
    logic capture_evt;
    logic match;
    logic cmp_hit;
    logic special;
    logic wrap;

    // ----------------------------------------
    // Core next-state logic
    // ----------------------------------------
    always_comb begin
        next_sync = {sync[1], sync[0], unit_event_pin_in};
        next_mode = unit_mode_field;
        next_value = capture_compare_value;
        next_timer = companion_timer_count;
        next_timer_run = timer_run;
        next_status = status;
        next_mask = mask;
        next_presc = presc;
        next_pin_out = unit_event_pin_out;
        capture_evt = 1'b0;
        cmp_hit = 1'b0;
        special = 1'b0;
        wrap = 1'b0;
        rise = sync[1] & ~sync[2];
        fall = ~sync[1] & sync[2];

        // Timer counts when running
        if (timer_run) begin
            next_timer = companion_timer_count + 16'h0001;
            wrap = (companion_timer_count == CCU_TMR_MAX);
        end

        // Software writes
        if (wr_en) begin
            unique case (addr)
                CCU_ADDR_CTRL: next_mode = wr_data[3:0];
                CCU_ADDR_VAL_LO: next_value[7:0] = wr_data;
                CCU_ADDR_VAL_HI: next_value[15:8] = wr_data;
                CCU_ADDR_TMR_LO: next_timer[7:0] = wr_data;
                CCU_ADDR_TMR_HI: next_timer[15:8] = wr_data;
                CCU_ADDR_TMR_CTRL: next_timer_run = wr_data[0];
                CCU_ADDR_STATUS: next_status = status & ~wr_data[1:0];
                CCU_ADDR_MASK: next_mask = wr_data[1:0];
                default: ;
            endcase
        end

        if (!is_capture(unit_mode_field)) begin
            next_presc = CCU_PRESC_RST;
        end else if (rise) begin
            next_presc = presc + 4'h1;
        end

        unique case (unit_mode_field)
            CCU_M_CAP_FALL: capture_evt = fall;
            CCU_M_CAP_RISE: capture_evt = rise;
            CCU_M_CAP_DIV4: capture_evt = rise && presc[1:0] == CCU_DIV4_LAST;
            CCU_M_CAP_DIV16: capture_evt = rise && presc == CCU_DIV16_LAST;
            default: capture_evt = 1'b0;
        endcase

        // whole count taken, old value lost
        if (capture_evt) begin
            next_value = companion_timer_count;
        end

        match = is_compare(unit_mode_field)
            && companion_timer_count == capture_compare_value;
        // act on first matching cycle only
        cmp_hit = match && !match_d;
        next_match_d = match;

        if (cmp_hit) begin
            unique case (unit_mode_field)
                CCU_M_CMP_HIGH: next_pin_out = 1'b1;
                CCU_M_CMP_LOW: next_pin_out = 1'b0;
                CCU_M_CMP_SPECIAL: special = 1'b1;
                default: ;
            endcase
        end
        if (!is_compare(unit_mode_field)) begin
            next_pin_out = 1'b0;
        end
        next_pin_oe = is_compare(unit_mode_field);

        // special trigger zeroes timer, no overflow
        if (special) begin
            next_timer = CCU_WORD_RST;
            wrap = 1'b0;
        end
        next_conv = special && SECOND_INSTANCE;

        if (capture_evt || cmp_hit) begin
            next_status[CCU_ST_REQ] = 1'b1;
        end
        if (wrap) begin
            next_status[CCU_ST_OVF] = 1'b1;
        end
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sync <= 3'h0;
            unit_mode_field <= CCU_MODE_RST;
            capture_compare_value <= CCU_WORD_RST;
            companion_timer_count <= CCU_WORD_RST;
            timer_run <= 1'b0;
            status <= CCU_FLAGS_RST;
            mask <= CCU_FLAGS_RST;
            presc <= CCU_PRESC_RST;
            match_d <= 1'b0;
            unit_event_pin_out <= 1'b0;
            unit_event_pin_oe <= 1'b0;
            irq <= 1'b0;
            converter_start <= 1'b0;
        end else begin
            sync <= next_sync;
            unit_mode_field <= next_mode;
            capture_compare_value <= next_value;
            companion_timer_count <= next_timer;
            timer_run <= next_timer_run;
            status <= next_status;
            mask <= next_mask;
            presc <= next_presc;
            match_d <= next_match_d;
            unit_event_pin_out <= next_pin_out;
            unit_event_pin_oe <= next_pin_oe;
            irq <= next_irq;
            converter_start <= next_conv;
        end
    end

    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    always_comb begin
        next_rd_data = 8'h00;
        if (rd_en) begin
            unique case (addr)
                CCU_ADDR_CTRL: next_rd_data = {4'h0, unit_mode_field};
                CCU_ADDR_VAL_LO: next_rd_data = capture_compare_value[7:0];
                CCU_ADDR_VAL_HI: next_rd_data = capture_compare_value[15:8];
                CCU_ADDR_TMR_LO: next_rd_data = companion_timer_count[7:0];
                CCU_ADDR_TMR_HI: next_rd_data = companion_timer_count[15:8];
                CCU_ADDR_TMR_CTRL: next_rd_data = {7'h00, timer_run};
                CCU_ADDR_STATUS: next_rd_data = {6'h00, status};
                CCU_ADDR_MASK: next_rd_data = {6'h00, mask};
                CCU_ADDR_PIN:
                    next_rd_data = {6'h00, unit_event_pin_out, sync[1]};
                default: next_rd_data = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_capture_latch: assert property (
        capture_evt |=> capture_compare_value == $past(companion_timer_count))
        else $error("Capture did not latch timer count");

    a_capture_rise: assert property (
        $past(unit_mode_field) == CCU_M_CAP_RISE && $rose(sync[2])
        |-> $past(capture_evt))
        else $error("Rising edge not captured");

    a_prescale_four: assert property (
        unit_mode_field == CCU_M_CAP_DIV4 && capture_evt
        |-> presc[1:0] == 2'h3)
        else $error("Divide-by-4 capture at wrong count");

    a_flag_sticky: assert property (
        status[CCU_ST_REQ] && !(wr_en && addr == CCU_ADDR_STATUS)
        |=> status[CCU_ST_REQ])
        else $error("Request flag dropped without software");

    a_overwrite_value: assert property (
        capture_evt && status[CCU_ST_REQ]
        |=> capture_compare_value == $past(companion_timer_count))
        else $error("Second capture did not overwrite");

    a_presc_clear: assert property (
        !is_capture(unit_mode_field) |=> presc == 4'h0)
        else $error("Prescaler not cleared outside capture");

    a_presc_keep: assert property (
        is_capture(unit_mode_field) && !rise |=> presc == $past(presc))
        else $error("Prescaler changed without edge");

    a_compare_high: assert property (
        cmp_hit && unit_mode_field == CCU_M_CMP_HIGH
        |=> unit_event_pin_out && unit_event_pin_oe)
        else $error("Pin not driven high on match");

    a_compare_flag: assert property (
        cmp_hit |=> status[CCU_ST_REQ])
        else $error("Match did not set flag");

    a_special_clear: assert property (
        special |=> companion_timer_count == 16'h0000
        && (!status[CCU_ST_OVF] || $past(status[CCU_ST_OVF])))
        else $error("Special trigger misbehaved");

    a_converter_start: assert property (
        special |=> converter_start == SECOND_INSTANCE)
        else $error("Converter start wrong");

    a_match_once: assert property (
        match && match_d && wr_en && addr == CCU_ADDR_STATUS
        && wr_data[CCU_ST_REQ] |=> !status[CCU_ST_REQ])
        else $error("Match acted twice");

    c_capture_div16: cover property (
        unit_mode_field == CCU_M_CAP_DIV16 && capture_evt);
    c_compare_low: cover property (
        cmp_hit && unit_mode_field == CCU_M_CMP_LOW);
    c_special: cover property (special);
    c_irq: cover property ($rose(irq));

endmodule

// [ccu_pin_partner.sv]
// Outside event source and load on the unit pin
`timescale 1ns/10ps
module ccu_pin_partner (
    // Pin from the unit
    input wire logic pin_out,
    input wire logic pin_oe,
    // Level the outside source wants
    input wire logic src_level,
    // Level seen on the pin
    output logic pin_level
);
    assign pin_level = pin_oe ? pin_out : src_level;
endmodule

// [ccu_pkg.sv]
// Constants shared by the capture/compare unit
package ccu_pkg;

    // ----------------------------------------
    // Register offsets (word index on the port)
    // ----------------------------------------
    localparam logic [3:0] CCU_ADDR_CTRL = 4'h0;
    localparam logic [3:0] CCU_ADDR_VAL_LO = 4'h1;
    localparam logic [3:0] CCU_ADDR_VAL_HI = 4'h2;
    localparam logic [3:0] CCU_ADDR_TMR_LO = 4'h3;
    localparam logic [3:0] CCU_ADDR_TMR_HI = 4'h4;
    localparam logic [3:0] CCU_ADDR_TMR_CTRL = 4'h5;
    localparam logic [3:0] CCU_ADDR_STATUS = 4'h6;
    localparam logic [3:0] CCU_ADDR_MASK = 4'h7;
    localparam logic [3:0] CCU_ADDR_PIN = 4'h8;

    // ----------------------------------------
    // Field positions and reset values
    // ----------------------------------------
    localparam int CCU_ST_REQ = 0;
    localparam int CCU_ST_OVF = 1;
    localparam logic [3:0] CCU_MODE_RST = 4'h0;
    localparam logic [15:0] CCU_WORD_RST = 16'h0000;
    localparam logic [15:0] CCU_TMR_MAX = 16'hFFFF;
    localparam logic [1:0] CCU_FLAGS_RST = 2'h0;
    localparam logic [3:0] CCU_PRESC_RST = 4'h0;
    localparam logic [1:0] CCU_DIV4_LAST = 2'h3;
    localparam logic [3:0] CCU_DIV16_LAST = 4'hF;

    // ----------------------------------------
    // Mode field encodings
    // ----------------------------------------
    localparam logic [3:0] CCU_M_OFF = 4'h0;
    localparam logic [3:0] CCU_M_CAP_FALL = 4'h4;
    localparam logic [3:0] CCU_M_CAP_RISE = 4'h5;
    localparam logic [3:0] CCU_M_CAP_DIV4 = 4'h6;
    localparam logic [3:0] CCU_M_CAP_DIV16 = 4'h7;
    localparam logic [3:0] CCU_M_CMP_HIGH = 4'h8;
    localparam logic [3:0] CCU_M_CMP_LOW = 4'h9;
    localparam logic [3:0] CCU_M_CMP_KEEP = 4'hA;
    localparam logic [3:0] CCU_M_CMP_SPECIAL = 4'hB;

endpackage

// [tb.sv]
// Self-checking bench for the capture/compare unit
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
$display("ERROR %0t: got %h want %h", $time, g, e); end end
module tb;
import ccu_pkg::*;
logic clk_sys;
logic sys_rst;
logic wr_en;
logic rd_en;
logic src;
logic pin_in;
logic pin_out;
logic pin_oe;
logic irq;
logic cstart;
logic [3:0] addr;
logic [7:0] wr_data;
logic [7:0] rd_data;
logic [7:0] d;
int errors;
int check_count;
int starts;

ccu_capture_compare #(.SECOND_INSTANCE(1'b1)) dut (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .unit_event_pin_in(pin_in),
    .unit_event_pin_out(pin_out), .unit_event_pin_oe(pin_oe), .irq(irq),
    .converter_start(cstart));
ccu_pin_partner partner (.pin_out(pin_out), .pin_oe(pin_oe),
    .src_level(src), .pin_level(pin_in));

initial begin
    clk_sys = 0;
    forever #20 clk_sys = ~clk_sys;
end
always @(posedge clk_sys) if (cstart === 1'b1) starts++;

task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    wr_en <= 1;
    addr <= a;
    wr_data <= v;
    @(posedge clk_sys);
    wr_en <= 0;
endtask
task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    rd_en <= 1;
    addr <= a;
    @(posedge clk_sys);
    rd_en <= 0;
    #1 d = rd_data;
endtask
task automatic pin(input logic v);
    @(posedge clk_sys);
    src <= v;
    repeat (5) @(posedge clk_sys);
endtask
task automatic rises(input int n);
    repeat (n) begin
        pin(1);
        pin(0);
    end
endtask
// timer stopped while loaded, then runs on the system clock only if run is set
task automatic tmr(input logic [15:0] t, input logic run);
    wr(CCU_ADDR_TMR_CTRL, 8'h00);
    wr(CCU_ADDR_TMR_LO, t[7:0]);
    wr(CCU_ADDR_TMR_HI, t[15:8]);
    wr(CCU_ADDR_TMR_CTRL, {7'h00, run});
endtask
task automatic stat(input logic [7:0] e);
    rd(CCU_ADDR_STATUS);
    `CHK(d, e)
endtask
task automatic val(input logic [15:0] v);
    rd(CCU_ADDR_VAL_LO);
    `CHK(d, v[7:0])
    rd(CCU_ADDR_VAL_HI);
    `CHK(d, v[15:8])
endtask

task automatic t_reset();
    wr(4'h9, 8'hFF);
    for (int a = 0; a < 10; a++) begin
        rd(a[3:0]);
        `CHK(d, 8'h00)
    end
    `CHK(irq, 1'b0)
endtask
task automatic t_capture();
    tmr(16'hA53C, 0);
    wr(CCU_ADDR_CTRL, {4'h0, CCU_M_CAP_RISE});
    wr(CCU_ADDR_STATUS, 8'h03);
    wr(CCU_ADDR_MASK, 8'h01);
    pin(0);
    `CHK(pin_oe, 1'b0)
    pin(1);
    rd(CCU_ADDR_PIN);
    `CHK(d, 8'h01)
    val(16'hA53C);
    `CHK(irq, 1'b1)
    tmr(16'h1234, 0);
    pin(0);
    pin(1);
    val(16'h1234);
    stat(8'h01);
    wr(CCU_ADDR_STATUS, 8'h01);
    stat(8'h00);
    `CHK(irq, 1'b0)
    wr(CCU_ADDR_MASK, 8'h00);
    wr(CCU_ADDR_CTRL, {4'h0, CCU_M_CAP_FALL});
    pin(1);
    tmr(16'h0F0E, 0);
    wr(CCU_ADDR_STATUS, 8'h03);
    pin(0);
    val(16'h0F0E);
    wr(CCU_ADDR_STATUS, 8'h03);
    pin(1);
    stat(8'h00);
    pin(0);
endtask
task automatic t_presc();
    // mask stays clear, flag cleared after change
    wr(CCU_ADDR_CTRL, 8'h00);
    wr(CCU_ADDR_CTRL, {4'h0, CCU_M_CAP_DIV4});
    wr(CCU_ADDR_STATUS, 8'h03);
    rises(3);
    stat(8'h00);
    rises(1);
    stat(8'h01);
    `CHK(irq, 1'b0)
    wr(CCU_ADDR_STATUS, 8'h03);
    rises(2);
    // off first, then the new setting
    wr(CCU_ADDR_CTRL, 8'h00);
    wr(CCU_ADDR_CTRL, {4'h0, CCU_M_CAP_DIV4});
    rises(3);
    stat(8'h00);
    rises(3);
    wr(CCU_ADDR_CTRL, {4'h0, CCU_M_CAP_DIV16});
    wr(CCU_ADDR_STATUS, 8'h03);
    rises(9);
    stat(8'h00);
    rises(1);
    stat(8'h01);
    wr(CCU_ADDR_STATUS, 8'h03);
    rises(15);
    stat(8'h00);
    rises(1);
    stat(8'h01);
endtask
task automatic t_rst();
    // a device reset clears the prescaler
    wr(CCU_ADDR_CTRL, {4'h0, CCU_M_CAP_DIV4});
    rises(2);
    @(posedge clk_sys);
    sys_rst <= 1;
    @(posedge clk_sys);
    sys_rst <= 0;
    rd(CCU_ADDR_CTRL);
    `CHK(d, 8'h00)
    wr(CCU_ADDR_CTRL, {4'h0, CCU_M_CAP_DIV4});
    rises(3);
    stat(8'h00);
    rises(1);
    stat(8'h01);
endtask
task automatic cmp(input logic [3:0] m, input logic e);
    wr(CCU_ADDR_STATUS, 8'h03);
    wr(CCU_ADDR_CTRL, {4'h0, m});
    tmr(16'h000C, 1);
    repeat (8) @(posedge clk_sys);
    wr(CCU_ADDR_TMR_CTRL, 8'h00);
    `CHK(pin_out, e)
    `CHK(pin_oe, 1'b1)
    rd(CCU_ADDR_PIN);
    `CHK(d, ({6'h00, e, e}))
    stat(8'h01);
endtask
task automatic t_compare();
    wr(CCU_ADDR_CTRL, 8'h00);
    wr(CCU_ADDR_VAL_LO, 8'h10);
    wr(CCU_ADDR_VAL_HI, 8'h00);
    cmp(CCU_M_CMP_HIGH, 1'b1);
    cmp(CCU_M_CMP_KEEP, 1'b1);
    cmp(CCU_M_CMP_LOW, 1'b0);
    tmr(16'h0010, 0);
    wr(CCU_ADDR_STATUS, 8'h03);
    repeat (6) @(posedge clk_sys);
    stat(8'h00);
    wr(CCU_ADDR_CTRL, 8'h00);
    tmr(16'hFFFE, 1);
    repeat (4) @(posedge clk_sys);
    stat(8'h02);
    wr(CCU_ADDR_STATUS, 8'h03);
    starts = 0;
    wr(CCU_ADDR_CTRL, {4'h0, CCU_M_CMP_SPECIAL});
    tmr(16'h000C, 1);
    repeat (6) @(posedge clk_sys);
    wr(CCU_ADDR_TMR_CTRL, 8'h00);
    rd(CCU_ADDR_TMR_HI);
    `CHK(d, 8'h00)
    rd(CCU_ADDR_TMR_LO);
    `CHK(d, 8'h03)
    stat(8'h01);
    `CHK(starts, 1)
endtask

task automatic give_verdict();
    $display("Checks %0d, errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask

initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    give_verdict();
end
initial begin
    sys_rst = 1;
    wr_en = 0;
    rd_en = 0;
    src = 0;
    addr = 0;
    wr_data = 0;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 0;
    t_reset();
    t_capture();
    t_presc();
    t_rst();
    t_compare();
    give_verdict();
end
endmodule
